// >>> dsf_assertions.sv
// concurrent checks on the ata side of the drive security block
`timescale 1ns/1ns
module dsf_assertions
(
  input wire MCLK_I,
  input wire ARST_N_I,
  input wire HARD_RST_I,
  input wire CMD_VALID_I,
  input wire [7:0] CMD_CODE_I,
  input wire DRQ_O,
  input wire DONE_O,
  input wire [7:0] ATA_STATUS_O,
  input wire [7:0] ATA_ERROR_O,
  input wire [15:0] IDENT_REV_O
);
  // -----------------------------
  // helper state
  // -----------------------------
  // a command is taken only while idle
  wire take = CMD_VALID_I && !DRQ_O && !ATA_STATUS_O[7] && !DONE_O && !HARD_RST_I;
  reg frz_q; // freeze seen since power-on
  reg prep_q; // last taken command was a prepare
  // helper flags follow the taken commands
  always @(posedge MCLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      frz_q <= 1'b0;
      prep_q <= 1'b0;
    end
    else if (take)
    begin
      frz_q <= frz_q | (CMD_CODE_I == 8'hF5);
      prep_q <= (CMD_CODE_I == 8'hF3);
    end
  end
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (!ARST_N_I);
  // -----------------------------
  // properties
  // -----------------------------
  a_freeze_done: assert property (take && CMD_CODE_I == 8'hF5
    |=> DONE_O && !DRQ_O && ATA_STATUS_O == 8'h50) else $error("freeze not done at once");
  a_frozen_refuse: assert property (take && frz_q && CMD_CODE_I inside {8'hF1, 8'hF2, 8'hF4,
    8'hF6} |=> DONE_O && !DRQ_O && ATA_STATUS_O == 8'h51) else $error("frozen command not refused");
  a_abort_code: assert property (DONE_O && ATA_STATUS_O[0]
    |-> ATA_ERROR_O == 8'h04 && ATA_STATUS_O == 8'h51) else $error("abort reported wrongly");
  a_error_bits: assert property (ATA_ERROR_O == 8'h00 || ATA_ERROR_O == 8'h04)
    else $error("error bit other than abort");
  a_setpw_entry: assert property (take && CMD_CODE_I == 8'hF1
    |=> (DRQ_O && ATA_STATUS_O == 8'h58) != (DONE_O && ATA_STATUS_O == 8'h51)) else $error("set password entry");
  a_drq_status: assert property (DRQ_O |-> ATA_STATUS_O == 8'h58 && !DONE_O)
    else $error("data phase status wrong");
  a_erase_noprep: assert property (take && CMD_CODE_I == 8'hF4 && !prep_q
    |=> DONE_O && ATA_STATUS_O == 8'h51) else $error("erase without prepare ran");
  a_unknown_cmd: assert property (take && !(CMD_CODE_I inside {[8'hF1:8'hF6]})
    |=> DONE_O && !DRQ_O && ATA_STATUS_O[0]) else $error("unknown command not refused");
  a_done_pulse: assert property (DONE_O |=> !DONE_O)
    else $error("completion longer than one cycle");
  a_rev_codes: assert property ($changed(IDENT_REV_O)
    |-> IDENT_REV_O != 16'h0000 && IDENT_REV_O != 16'hFFFF) else $error("reserved revision stored");
endmodule // dsf_assertions

// >>> dsf_consts.vh
// constants for the drive security command block
// Function
// (RULE1) freeze command enters frozen state, no data
// (RULE2) after freeze, security-changing commands are refused
// (RULE3) only power removal leaves frozen state
// (RULE4) frozen refuses set, unlock, disable, erase
// (RULE5) only abort bit may be set in error
// (RULE6) set password takes one sector, selects target
// (RULE7) lock armed now, takes effect after reset
// (RULE8) control bit 0 selects master or user
// (RULE9) control bit 8 selects maximum or high
// (RULE10) words 1-16 hold 32 significant password bytes
// (RULE11) word 17 revision code, reported as word 92
// (RULE12) revision 0000h/FFFFh accepted but not stored
// (RULE13) user/high: user or master password unlocks
// (RULE14) user/maximum: only user password unlocks
// (RULE15) master identifier stores master, no lock enable
// (RULE16) high level: master password may unlock
// (RULE17) maximum level recovery only by erase sequence
// (RULE18) erase without preceding prepare is aborted
// (RULE19) reject: not busy, error, abort, no data
`ifndef DSF_CONSTS_VH
`define DSF_CONSTS_VH
// ----------------------------------------
// command codes
// ----------------------------------------
`define DSF_CMD_SETPW 8'hF1
`define DSF_CMD_UNLOCK 8'hF2
`define DSF_CMD_PREP 8'hF3
`define DSF_CMD_ERASE 8'hF4
`define DSF_CMD_FREEZE 8'hF5
`define DSF_CMD_DISPW 8'hF6
// ----------------------------------------
// sector layout
// ----------------------------------------
`define DSF_W_CTRL 8'h00
`define DSF_W_PW_LO 8'h01
`define DSF_W_PW_HI 8'h10
`define DSF_W_REV 8'h11
`define DSF_W_LAST 8'hFF
`define DSF_CTL_ID 0
`define DSF_CTL_LVL 8
`define DSF_REV_NONE0 16'h0000
`define DSF_REV_NONE1 16'hFFFF
`define DSF_TRIES 3'h5
// ----------------------------------------
// status and error bits
// ----------------------------------------
`define DSF_ST_BSY 7
`define DSF_ST_RDY 6
`define DSF_ST_DSC 4
`define DSF_ST_DRQ 3
`define DSF_ST_ERR 0
`define DSF_ER_ABT 2
// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define DSF_A_ERR 8'h00
`define DSF_A_STAT 8'h04
`define DSF_A_SEC 8'h08
`define DSF_A_REV 8'h0C
`define DSF_A_IRQS 8'h10
`define DSF_A_IRQM 8'h14
`define DSF_IRQ_DONE 0
`define DSF_IRQ_ABT 1
`define DSF_RESP_OK 2'h0
`define DSF_RESP_ERR 2'h2
`endif

// >>> dsf_host_model.sv
// model of the ata host issuing commands and data-out sectors
`timescale 1ns/1ns
module dsf_host_model
(
  input wire clk_i,
  input wire drq_i,
  output reg cmd_valid_o,
  output reg [7:0] cmd_code_o,
  output reg word_valid_o,
  output reg [15:0] word_o
);
  // idle bus at time zero
  initial
  begin
    cmd_valid_o = 1'b0;
    cmd_code_o = 8'h00;
    word_valid_o = 1'b0;
    word_o = 16'h0000;
  end
  // one-cycle command strobe; code inverted afterwards so it is never stale
  task send_cmd(input [7:0] c);
    begin
      @(posedge clk_i);
      cmd_valid_o <= 1'b1;
      cmd_code_o <= c;
      @(posedge clk_i);
      cmd_valid_o <= 1'b0;
      cmd_code_o <= ~c;
    end
  endtask
  // one whole sector: control, password words, revision, changing filler
  task send_sector(input [15:0] ctl, input [15:0] pw, input [15:0] rv);
    integer i;
    begin
      for (i = 0; i < 256; i = i + 1)
      begin
        @(posedge clk_i);
        word_valid_o <= drq_i;
        word_o <= (i == 0) ? ctl : (i <= 16) ? pw ^ i[15:0] : (i == 17) ? rv : ~i[15:0];
      end
      @(posedge clk_i);
      word_valid_o <= 1'b0;
      word_o <= ~word_o;
    end
  endtask
endmodule // dsf_host_model

// >>> dsf_top.v
// drive security state logic with ata-side ports and axi4-lite registers
`timescale 1ns/1ns
`include "dsf_consts.vh"
module dsf_top
(
  input wire MCLK_I,
  input wire ARST_N_I,
  input wire HARD_RST_I,
  input wire CMD_VALID_I,
  input wire [7:0] CMD_CODE_I,
  input wire WORD_VALID_I,
  input wire [15:0] WORD_I,
  output reg DRQ_O,
  output reg DONE_O,
  output reg [7:0] ATA_STATUS_O,
  output reg [7:0] ATA_ERROR_O,
  output reg [15:0] IDENT_REV_O,
  output reg IRQ_O,
  input wire [7:0] AWADDR_I,
  input wire AWVALID_I,
  output reg AWREADY_O,
  input wire [31:0] WDATA_I,
  input wire [3:0] WSTRB_I,
  input wire WVALID_I,
  output reg WREADY_O,
  output reg [1:0] BRESP_O,
  output reg BVALID_O,
  input wire BREADY_I,
  input wire [7:0] ARADDR_I,
  input wire ARVALID_I,
  output reg ARREADY_O,
  output reg [31:0] RDATA_O,
  output reg [1:0] RRESP_O,
  output reg RVALID_O,
  input wire RREADY_I
);

// ----------------------------------------
// states and helpers
// ----------------------------------------
localparam S_IDLE = 3'b001; // ready for a command
localparam S_XFER = 3'b010; // collecting the data-out sector
localparam S_EXEC = 3'b100; // acting on the sector

// full-width password compare, every byte counts
function pw_eq;
  input [255:0] a;
  input [255:0] b;
  begin
    pw_eq = (a == b); // RULE10
  end
endfunction

// ----------------------------------------
// state
// ----------------------------------------
reg [2:0] state_q; // command phase
reg [7:0] op_q; // command being run
reg [7:0] widx_q; // word index in sector
reg [15:0] ctl_q; // control word 0
reg [255:0] pw_q; // incoming password
reg [15:0] rev_in_q; // incoming revision code
reg [255:0] user_pw_q; // stored user password
reg [255:0] mast_pw_q; // stored master password
reg [15:0] rev_q; // stored master revision
reg frozen_q; // frozen until power-off
reg enabled_q; // lock feature enabled
reg locked_q; // device lock mode
reg max_lvl_q; // maximum security level
reg prep_q; // erase prepare just done
reg [2:0] tries_q; // unlock attempts left
reg [1:0] irq_st_q; // sticky event bits
reg [1:0] irq_mk_q; // event mask
reg ev_done; // completion pulse source
reg ev_abt; // abort pulse source

// ----------------------------------------
// decode of the incoming sector
// ----------------------------------------
wire id_master = ctl_q[`DSF_CTL_ID]; // RULE8
wire lvl_max = ctl_q[`DSF_CTL_LVL]; // RULE9
wire rev_ok = (rev_in_q != `DSF_REV_NONE0) && (rev_in_q != `DSF_REV_NONE1); // RULE12
// unlock match: user always, master only at high level
wire pw_match = id_master ? (!max_lvl_q && pw_eq(pw_q, mast_pw_q)) // RULE16 RULE14
                          : pw_eq(pw_q, user_pw_q); // RULE13
wire take_cmd = CMD_VALID_I && state_q[0];
wire take_word = WORD_VALID_I && DRQ_O;
wire sec_cmd = (CMD_CODE_I == `DSF_CMD_SETPW) || (CMD_CODE_I == `DSF_CMD_UNLOCK)
             || (CMD_CODE_I == `DSF_CMD_DISPW) || (CMD_CODE_I == `DSF_CMD_ERASE);

// ----------------------------------------
// command sequencer
// ----------------------------------------
// one command at a time; a refused one completes at once with abort
always @(posedge MCLK_I or negedge ARST_N_I)
begin
  if (!ARST_N_I)
  begin
    state_q <= S_IDLE;
    op_q <= 8'h00;
    widx_q <= 8'h00;
    ctl_q <= 16'h0000;
    pw_q <= {256{1'b0}};
    rev_in_q <= 16'h0000;
    user_pw_q <= {256{1'b0}};
    mast_pw_q <= {256{1'b0}};
    rev_q <= 16'h0000;
    frozen_q <= 1'b0; // RULE3
    enabled_q <= 1'b0;
    locked_q <= 1'b0;
    max_lvl_q <= 1'b0;
    prep_q <= 1'b0;
    tries_q <= `DSF_TRIES;
    DRQ_O <= 1'b0;
    DONE_O <= 1'b0;
    ATA_STATUS_O <= 8'h50;
    ATA_ERROR_O <= 8'h00;
    ev_done <= 1'b0;
    ev_abt <= 1'b0;
  end
  else
  begin
    DONE_O <= 1'b0;
    ev_done <= 1'b0;
    ev_abt <= 1'b0;
    // hard reset arms the lock but never clears frozen
    if (HARD_RST_I && state_q[0])
    begin
      locked_q <= enabled_q; // RULE7
      tries_q <= `DSF_TRIES;
      prep_q <= 1'b0;
    end
    case (state_q)
      S_IDLE:
      begin
        if (take_cmd && !HARD_RST_I)
        begin
          op_q <= CMD_CODE_I;
          widx_q <= 8'h00;
          // any command but prepare breaks the erase sequence
          prep_q <= (CMD_CODE_I == `DSF_CMD_PREP);
          if (CMD_CODE_I == `DSF_CMD_FREEZE)
          begin
            frozen_q <= 1'b1; // RULE1
            DONE_O <= 1'b1;
            ev_done <= 1'b1;
            ATA_STATUS_O <= 8'h50;
            ATA_ERROR_O <= 8'h00;
          end
          else if (CMD_CODE_I == `DSF_CMD_PREP)
          begin
            DONE_O <= 1'b1;
            ev_done <= 1'b1;
            ATA_STATUS_O <= 8'h50;
            ATA_ERROR_O <= 8'h00;
          end
          else if (!sec_cmd || (frozen_q && sec_cmd) // RULE2 RULE4
                   || (CMD_CODE_I == `DSF_CMD_ERASE && !prep_q) // RULE18 RULE17
                   || (tries_q == 3'h0 && CMD_CODE_I != `DSF_CMD_SETPW
                       && CMD_CODE_I != `DSF_CMD_ERASE))
          begin
            // refused: busy clear, error and abort, no data phase
            DONE_O <= 1'b1; // RULE19
            ev_done <= 1'b1;
            ev_abt <= 1'b1;
            ATA_STATUS_O <= 8'h51; // RULE19
            ATA_ERROR_O <= 8'h04; // RULE5
          end
          else
          begin
            // open the data-out phase for one sector
            state_q <= S_XFER; // RULE6
            DRQ_O <= 1'b1;
            ATA_STATUS_O <= 8'h58;
            ATA_ERROR_O <= 8'h00;
          end
        end
      end
      S_XFER:
      begin
        if (take_word)
        begin
          widx_q <= widx_q + 8'h01;
          if (widx_q == `DSF_W_CTRL)
            ctl_q <= WORD_I;
          // password words land low word first
          if (widx_q >= `DSF_W_PW_LO && widx_q <= `DSF_W_PW_HI)
            pw_q <= {WORD_I, pw_q[255:16]}; // RULE10
          if (widx_q == `DSF_W_REV)
            rev_in_q <= WORD_I; // RULE11
          if (widx_q == `DSF_W_LAST)
          begin
            DRQ_O <= 1'b0;
            ATA_STATUS_O <= 8'hD0;
            state_q <= S_EXEC;
          end
        end
      end
      S_EXEC:
      begin
        state_q <= S_IDLE;
        DONE_O <= 1'b1;
        ev_done <= 1'b1;
        ATA_STATUS_O <= 8'h50;
        ATA_ERROR_O <= 8'h00;
        case (op_q)
          `DSF_CMD_SETPW:
          begin
            if (id_master)
            begin
              // master stored, lock feature untouched
              mast_pw_q <= pw_q; // RULE15
              if (rev_ok)
                rev_q <= rev_in_q; // RULE12
            end
            else
            begin
              // user stored; lock applies only after a reset
              user_pw_q <= pw_q; // RULE13 RULE14
              max_lvl_q <= lvl_max; // RULE9
              enabled_q <= 1'b1; // RULE7
            end
          end
          `DSF_CMD_UNLOCK, `DSF_CMD_DISPW:
          begin
            if (pw_match)
            begin
              locked_q <= 1'b0;
              if (op_q == `DSF_CMD_DISPW)
                enabled_q <= 1'b0;
            end
            else
            begin
              // mismatch costs one attempt
              tries_q <= tries_q - 3'h1;
              ev_abt <= 1'b1;
              ATA_STATUS_O <= 8'h51; // RULE19
              ATA_ERROR_O <= 8'h04; // RULE5
            end
          end
          `DSF_CMD_ERASE:
          begin
            // erase drops the user password and the lock
            user_pw_q <= {256{1'b0}}; // RULE17
            enabled_q <= 1'b0;
            locked_q <= 1'b0;
            max_lvl_q <= 1'b0;
          end
          default:
          begin
            ATA_STATUS_O <= 8'h51;
            ATA_ERROR_O <= 8'h04;
          end
        endcase
      end
      default:
      begin
        state_q <= S_IDLE;
        DRQ_O <= 1'b0;
      end
    endcase
  end
end

// ----------------------------------------
// identify word 92 copy
// ----------------------------------------
always @(posedge MCLK_I or negedge ARST_N_I)
begin
  if (!ARST_N_I)
    IDENT_REV_O <= 16'h0000;
  else
    IDENT_REV_O <= rev_q; // RULE11
end

// ----------------------------------------
// interrupt status and output
// ----------------------------------------
wire aw_go = AWVALID_I && WVALID_I && !BVALID_O && !AWREADY_O;
wire [1:0] w1c = (aw_go && AWADDR_I == `DSF_A_IRQS && WSTRB_I[0]) ? WDATA_I[1:0] : 2'b00;
wire [1:0] ev_set = {ev_abt, ev_done};

// sticky bits; a new event wins over a clear in the same cycle
always @(posedge MCLK_I or negedge ARST_N_I)
begin
  if (!ARST_N_I)
  begin
    irq_st_q <= 2'b00;
    IRQ_O <= 1'b0;
  end
  else
  begin
    irq_st_q <= (irq_st_q & ~w1c) | ev_set;
    IRQ_O <= |(((irq_st_q & ~w1c) | ev_set) & irq_mk_q);
  end
end

// ----------------------------------------
// axi4-lite write channel
// ----------------------------------------
// address and data are taken together, response one cycle later
always @(posedge MCLK_I or negedge ARST_N_I)
begin
  if (!ARST_N_I)
  begin
    AWREADY_O <= 1'b0;
    WREADY_O <= 1'b0;
    BVALID_O <= 1'b0;
    BRESP_O <= `DSF_RESP_OK;
    irq_mk_q <= 2'b00;
  end
  else
  begin
    AWREADY_O <= aw_go;
    WREADY_O <= aw_go;
    if (aw_go)
    begin
      BVALID_O <= 1'b1;
      if (AWADDR_I == `DSF_A_IRQM)
      begin
        BRESP_O <= `DSF_RESP_OK;
        if (WSTRB_I[0])
          irq_mk_q <= WDATA_I[1:0];
      end
      else if (AWADDR_I == `DSF_A_IRQS)
        BRESP_O <= `DSF_RESP_OK;
      else if (AWADDR_I == `DSF_A_ERR || AWADDR_I == `DSF_A_STAT
               || AWADDR_I == `DSF_A_SEC || AWADDR_I == `DSF_A_REV)
        BRESP_O <= `DSF_RESP_OK; // read-only, write ignored
      else
        BRESP_O <= `DSF_RESP_ERR;
    end
    else if (BVALID_O && BREADY_I)
      BVALID_O <= 1'b0;
  end
end

// ----------------------------------------
// axi4-lite read channel
// ----------------------------------------
wire ar_go = ARVALID_I && !RVALID_O && !ARREADY_O;

// read data mux, unmapped reads give zero and slverr
always @(posedge MCLK_I or negedge ARST_N_I)
begin
  if (!ARST_N_I)
  begin
    ARREADY_O <= 1'b0;
    RVALID_O <= 1'b0;
    RDATA_O <= 32'h00000000;
    RRESP_O <= `DSF_RESP_OK;
  end
  else
  begin
    ARREADY_O <= ar_go;
    if (ar_go)
    begin
      RVALID_O <= 1'b1;
      RRESP_O <= `DSF_RESP_OK;
      case (ARADDR_I)
        `DSF_A_ERR: RDATA_O <= {24'h000000, ATA_ERROR_O};
        `DSF_A_STAT: RDATA_O <= {24'h000000, ATA_STATUS_O};
        `DSF_A_SEC: RDATA_O <= {24'h000000, tries_q, prep_q, max_lvl_q,
                                locked_q, enabled_q, frozen_q};
        `DSF_A_REV: RDATA_O <= {16'h0000, rev_q};
        `DSF_A_IRQS: RDATA_O <= {30'h00000000, irq_st_q};
        `DSF_A_IRQM: RDATA_O <= {30'h00000000, irq_mk_q};
        default:
        begin
          RDATA_O <= 32'h00000000;
          RRESP_O <= `DSF_RESP_ERR;
        end
      endcase
    end
    else if (RVALID_O && RREADY_I)
      RVALID_O <= 1'b0;
  end
end

endmodule // dsf_top

// >>> dsf_top_tb_top.sv
// self-checking testbench for the drive security block
`timescale 1ns/1ns
module dsf_top_tb_top;
  reg clk = 1'b0; // 20 MHz clock
  reg rst_n = 1'b0; // power-on reset
  reg hrst = 1'b0; // hard reset level
  reg [7:0] awaddr = 8'h00;
  reg awvalid = 1'b0;
  reg [31:0] wdata = 32'h0;
  reg wvalid = 1'b0;
  reg bready = 1'b0;
  reg [7:0] araddr = 8'h00;
  reg arvalid = 1'b0;
  reg rready = 1'b0;
  wire cv, wv, drq, done, irq, awr, wrd, bv, arr, rv;
  wire [1:0] bresp, rresp;
  wire [7:0] code, st, er;
  wire [15:0] word, rev;
  wire [31:0] rdata;
  integer num_errors = 0;
  integer n_checks = 0;
  integer k;
  reg [31:0] d;
  reg [31:0] cl = 32'hF6F4F2F1; // codes refused while frozen
  initial
    forever #25 clk = ~clk;
  dsf_host_model host (.clk_i(clk), .drq_i(drq), .cmd_valid_o(cv), .cmd_code_o(code),
    .word_valid_o(wv), .word_o(word));
  dsf_top dut (.MCLK_I(clk), .ARST_N_I(rst_n), .HARD_RST_I(hrst), .CMD_VALID_I(cv),
    .CMD_CODE_I(code), .WORD_VALID_I(wv), .WORD_I(word), .DRQ_O(drq), .DONE_O(done),
    .ATA_STATUS_O(st), .ATA_ERROR_O(er), .IDENT_REV_O(rev), .IRQ_O(irq), .AWADDR_I(awaddr),
    .AWVALID_I(awvalid), .AWREADY_O(awr), .WDATA_I(wdata), .WSTRB_I(4'hF), .WVALID_I(wvalid),
    .WREADY_O(wrd), .BRESP_O(bresp), .BVALID_O(bv), .BREADY_I(bready), .ARADDR_I(araddr),
    .ARVALID_I(arvalid), .ARREADY_O(arr), .RDATA_O(rdata), .RRESP_O(rresp), .RVALID_O(rv),
    .RREADY_I(rready));
  // verdict and end of run
  task end_of_test;
    begin
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  // compare and count
  task chk(input [63:0] nm, input [31:0] e, input [31:0] g);
    begin
      n_checks = n_checks + 1;
      if (g !== e)
      begin
        num_errors = num_errors + 1;
        $display("[ERR] %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  // a used-up wait ends the run
  task bound(input integer n);
    begin
      if (n >= 400)
      begin
        num_errors = num_errors + 1;
        $display("[ERR] wait expected answer seen timeout");
        end_of_test;
      end
    end
  endtask
  // axi write, both channels offered together
  task axi_w(input [7:0] a, input [31:0] v, input [1:0] e);
    integer n;
    begin
      @(posedge clk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      n = 0;
      @(posedge clk);
      while (bv !== 1'b1 && n < 400)
      begin
        @(posedge clk);
        n = n + 1;
      end
      bound(n);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      bready <= 1'b0;
      chk("bresp", e, bresp);
      chk("awready", 1'b1, awr);
      chk("wready", 1'b1, wrd);
    end
  endtask
  // axi read
  task axi_r(input [7:0] a, input [1:0] e, output [31:0] v);
    integer n;
    begin
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      n = 0;
      @(posedge clk);
      while (rv !== 1'b1 && n < 400)
      begin
        @(posedge clk);
        n = n + 1;
      end
      bound(n);
      v = rdata;
      arvalid <= 1'b0;
      rready <= 1'b0;
      chk("rresp", e, rresp);
      chk("arready", 1'b1, arr);
    end
  endtask
  // one command, its sector if asked for, then its completion
  task run(input [7:0] c, input [15:0] ctl, input [15:0] pw, input [15:0] rvc, input dat,
    input [7:0] est);
    integer n;
    reg sd;
    begin
      host.send_cmd(c);
      #1;
      sd = drq;
      if (sd)
        host.send_sector(ctl, pw, rvc);
      n = 0;
      while (done !== 1'b1 && n < 400)
      begin
        @(posedge clk);
        #1;
        n = n + 1;
      end
      bound(n);
      chk("drq", dat, sd);
      chk("status", est, st);
      chk("error", est[0] ? 8'h04 : 8'h00, er);
    end
  endtask
  // hard reset pulse while idle
  task hard_reset;
    begin
      @(posedge clk);
      hrst <= 1'b1;
      @(posedge clk);
      hrst <= 1'b0;
    end
  endtask
  // let registered flags land
  task settle;
    begin
      repeat (2) @(posedge clk);
      #1;
    end
  endtask
  // main sequence
  initial
  begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    settle;
    chk("status", 8'h50, st);
    axi_r(8'h40, 2'h2, d);
    axi_w(8'h40, 32'h0, 2'h2);
    run(8'hF1, 16'h0001, 16'hA5A5, 16'h1234, 1'b1, 8'h50);
    // identify copy trails the stored code by one cycle
    settle;
    chk("rev", 16'h1234, rev);
    axi_r(8'h0C, 2'h0, d);
    chk("rev_reg", 32'h1234, d);
    axi_r(8'h08, 2'h0, d);
    chk("sec", 5'h00, d[4:0]);
    run(8'hF1, 16'h0101, 16'hA5A5, 16'hFFFF, 1'b1, 8'h50);
    settle;
    chk("rev", 16'h1234, rev);
    run(8'hF1, 16'h0000, 16'h3C3C, 16'h0000, 1'b1, 8'h50);
    axi_r(8'h08, 2'h0, d);
    chk("sec", 5'h02, d[4:0]);
    hard_reset;
    axi_r(8'h08, 2'h0, d);
    chk("sec", 5'h06, d[4:0]);
    run(8'hF2, 16'h0000, 16'h3C3D, 16'h0000, 1'b1, 8'h51);
    run(8'hF2, 16'h0001, 16'hA5A5, 16'h0000, 1'b1, 8'h50);
    axi_r(8'h08, 2'h0, d);
    chk("sec", 5'h02, d[4:0]);
    run(8'hF4, 16'h0000, 16'h3C3C, 16'h0000, 1'b0, 8'h51);
    settle;
    chk("irq", 1'b0, irq);
    axi_r(8'h10, 2'h0, d);
    chk("irq_st", 2'h3, d[1:0]);
    axi_w(8'h14, 32'h2, 2'h0);
    settle;
    chk("irq", 1'b1, irq);
    axi_w(8'h10, 32'h3, 2'h0);
    settle;
    chk("irq", 1'b0, irq);
    run(8'hF3, 16'h0000, 16'h0000, 16'h0000, 1'b0, 8'h50);
    run(8'hF4, 16'h0000, 16'h3C3C, 16'h0000, 1'b1, 8'h50);
    axi_r(8'h08, 2'h0, d);
    chk("sec", 2'h0, d[2:1]);
    // user password at maximum level: master no longer unlocks
    run(8'hF1, 16'h0100, 16'h1111, 16'h0000, 1'b1, 8'h50);
    run(8'hF2, 16'h0001, 16'hA5A5, 16'h0000, 1'b1, 8'h51);
    run(8'hF2, 16'h0000, 16'h1111, 16'h0000, 1'b1, 8'h50);
    axi_r(8'h08, 2'h0, d);
    chk("sec", 5'h0A, d[4:0]);
    run(8'hF5, 16'h0000, 16'h0000, 16'h0000, 1'b0, 8'h50);
    for (k = 0; k < 4; k = k + 1)
      run(cl[8*k +: 8], 16'h0000, 16'h3C3C, 16'h0000, 1'b0, 8'h51);
    run(8'h00, 16'h0000, 16'h0000, 16'h0000, 1'b0, 8'h51);
    hard_reset;
    axi_r(8'h08, 2'h0, d);
    chk("frozen", 1'b1, d[0]);
    run(8'hF1, 16'h0000, 16'h3C3C, 16'h0000, 1'b0, 8'h51);
    // power removal is the only way out of the frozen state
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    settle;
    chk("status", 8'h50, st);
    axi_r(8'h08, 2'h0, d);
    chk("frozen", 1'b0, d[0]);
    run(8'hF1, 16'h0001, 16'hA5A5, 16'h0000, 1'b1, 8'h50);
    end_of_test;
  end
endmodule // dsf_top_tb_top
bind dsf_top dsf_assertions chk_i (.MCLK_I(MCLK_I), .ARST_N_I(ARST_N_I), .HARD_RST_I(HARD_RST_I),
  .CMD_VALID_I(CMD_VALID_I), .CMD_CODE_I(CMD_CODE_I), .DRQ_O(DRQ_O), .DONE_O(DONE_O),
  .ATA_STATUS_O(ATA_STATUS_O), .ATA_ERROR_O(ATA_ERROR_O), .IDENT_REV_O(IDENT_REV_O));
